//--- cor_pkg.sv
// Functional notes
// - Four 13-bit DC correction words, one per converter channel, each counted in converter LSBs.
// - With auto-sync on, a write to the channel A register moves the A and B words into use together.
// - A write to the channel B register only stages the B word and leaves the applied B word alone.
// - With auto-sync on, a write to the channel C register moves the C and D words into use together.
// - A write to the channel D register only stages D; the applied D word waits for a C/D sync.
// - On a FIFO sync the 3-bit read-pointer preset is loaded into the input FIFO read pointer.
// - After reset the preset and channel B register reads 0x8000: preset 100, offset zero.
// - After reset the channel A, C and D registers read zero, reserved bits included.
package cor_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int COR_DATA_W = 32;
  localparam int COR_ADDR_W = 12;
  localparam int COR_REG_W = 16;
  localparam int COR_OFS_W = 13;
  localparam int COR_PRESET_W = 3;
  localparam int COR_IDX_W = 8;
  localparam int COR_CNT_W = 8;

  // ****************************************
  // register indices (byte address is four times the index)
  // ****************************************
  localparam logic [COR_IDX_W-1:0] COR_IDX_CHAN_A = 8'h08;
  localparam logic [COR_IDX_W-1:0] COR_IDX_PRESET_B = 8'h09;
  localparam logic [COR_IDX_W-1:0] COR_IDX_CHAN_C = 8'h0A;
  localparam logic [COR_IDX_W-1:0] COR_IDX_CHAN_D = 8'h0B;
  localparam logic [COR_IDX_W-1:0] COR_IDX_AUTO_SYNC = 8'h1E;
  localparam logic [COR_IDX_W-1:0] COR_IDX_APPLIED_AB = 8'h40;
  localparam logic [COR_IDX_W-1:0] COR_IDX_APPLIED_CD = 8'h41;
  localparam logic [COR_IDX_W-1:0] COR_IDX_SYNC_CTRL = 8'h42;

  // ****************************************
  // field positions
  // ****************************************
  localparam int COR_OFS_LSB = 0;
  localparam int COR_PRESET_LSB = 13;
  localparam int COR_AS_AB_BIT = 0;
  localparam int COR_AS_CD_BIT = 1;
  localparam int COR_APPL_LO_LSB = 0;
  localparam int COR_APPL_HI_LSB = 16;
  localparam int COR_CNT_AB_LSB = 0;
  localparam int COR_CNT_CD_LSB = 8;

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [COR_REG_W-1:0] COR_RST_CHAN_A = 16'h0000;
  localparam logic [COR_REG_W-1:0] COR_RST_PRESET_B = 16'h8000;
  localparam logic [COR_REG_W-1:0] COR_RST_CHAN_C = 16'h0000;
  localparam logic [COR_REG_W-1:0] COR_RST_CHAN_D = 16'h0000;
  localparam logic [1:0] COR_RST_AUTO_SYNC = 2'h0;
  localparam logic [COR_REG_W-1:0] COR_MASK_OFS_ONLY = 16'h1FFF;
  localparam logic [COR_REG_W-1:0] COR_MASK_PRESET_OFS = 16'hFFFF;

endpackage

//--- cor_pair_apply.sv
`timescale 1ns/1ps
// ****************************************
// applied correction words of one channel pair
// ****************************************
module cor_pair_apply #(
  parameter int W = 13
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic load_i,
  input wire logic [W-1:0] first_i,
  input wire logic [W-1:0] second_i,
  output logic [W-1:0] first_o,
  output logic [W-1:0] second_o
);
  import cor_pkg::*;

  logic [W-1:0] first_reg;
  logic [W-1:0] second_reg;

  // both words change on the same edge, never one alone
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_reg <= '0;
      second_reg <= '0;
    end else if (load_i) begin
      first_reg <= first_i;
      second_reg <= second_i;
    end
  end

  assign first_o = first_reg;
  assign second_o = second_reg;

endmodule

//--- cor_regs.sv
`timescale 1ns/1ps
// ****************************************
// channel offset correction register bank
// ****************************************
module cor_regs #(
  parameter int CNT_W = cor_pkg::COR_CNT_W
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [cor_pkg::COR_ADDR_W-1:0] paddr_i,
  input wire logic [cor_pkg::COR_DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [cor_pkg::COR_DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic fifo_sync_i,
  input wire logic ext_sync_i,
  output logic [cor_pkg::COR_OFS_W-1:0] chan_a_dc_correction_o,
  output logic [cor_pkg::COR_OFS_W-1:0] chan_b_dc_correction_o,
  output logic [cor_pkg::COR_OFS_W-1:0] chan_c_dc_correction_o,
  output logic [cor_pkg::COR_OFS_W-1:0] chan_d_dc_correction_o,
  output logic [cor_pkg::COR_PRESET_W-1:0] fifo_rd_ptr_o,
  output logic fifo_rd_ptr_load_o
);
  import cor_pkg::*;

  // ****************************************
  // decode helpers
  // ****************************************

  // true when the byte address lands exactly on the word of an index
  function automatic logic addr_hit(input logic [COR_ADDR_W-1:0] addr,
                                    input logic [COR_IDX_W-1:0] idx);
    logic [COR_ADDR_W-1:0] byte_addr;
    byte_addr = {{(COR_ADDR_W-COR_IDX_W-2){1'b0}}, idx, 2'b00};
    return addr == byte_addr;
  endfunction

  // merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [COR_REG_W-1:0] lane_merge(input logic [COR_REG_W-1:0] old_val,
                                                      input logic [COR_DATA_W-1:0] wdata,
                                                      input logic [3:0] strb,
                                                      input logic [COR_REG_W-1:0] mask);
    logic [COR_REG_W-1:0] merged;
    merged = old_val;
    if (strb[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = wdata[15:8];
    end
    return merged & mask;
  endfunction

  // ****************************************
  // apb handshake
  // ****************************************
  logic pready_reg;
  logic pslverr_reg;
  logic [COR_DATA_W-1:0] prdata_reg;
  logic access_ph;
  logic xfer_done;
  logic wr_ok;

  assign access_ph = psel_i & penable_i;
  // one wait state: the answer comes in the second access cycle
  assign xfer_done = access_ph & pready_reg;
  // an errored write stores nothing
  assign wr_ok = xfer_done & pwrite_i & ~pslverr_reg;

  // pready pulses for one cycle per transfer, from a flop
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= access_ph & ~pready_reg;
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_d;
  logic hit_as;
  logic hit_appl_ab;
  logic hit_appl_cd;
  logic hit_sync;
  logic hit_any;
  logic hit_ro;

  assign hit_a = addr_hit(paddr_i, COR_IDX_CHAN_A);
  assign hit_b = addr_hit(paddr_i, COR_IDX_PRESET_B);
  assign hit_c = addr_hit(paddr_i, COR_IDX_CHAN_C);
  assign hit_d = addr_hit(paddr_i, COR_IDX_CHAN_D);
  assign hit_as = addr_hit(paddr_i, COR_IDX_AUTO_SYNC);
  assign hit_appl_ab = addr_hit(paddr_i, COR_IDX_APPLIED_AB);
  assign hit_appl_cd = addr_hit(paddr_i, COR_IDX_APPLIED_CD);
  assign hit_sync = addr_hit(paddr_i, COR_IDX_SYNC_CTRL);
  assign hit_any = hit_a | hit_b | hit_c | hit_d | hit_as | hit_appl_ab | hit_appl_cd |
                   hit_sync;
  // applied words are a live view of the datapath; writing them is refused
  assign hit_ro = hit_appl_ab | hit_appl_cd;

  // error flag judged in the first access cycle, shown with pready
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pslverr_reg <= 1'b0;
    end else if (access_ph & ~pready_reg) begin
      pslverr_reg <= ~hit_any | (pwrite_i & hit_ro);
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  // ****************************************
  // staged registers
  // ****************************************
  logic [COR_REG_W-1:0] chan_a_reg;
  logic [COR_REG_W-1:0] preset_b_reg;
  logic [COR_REG_W-1:0] chan_c_reg;
  logic [COR_REG_W-1:0] chan_d_reg;
  logic [1:0] auto_sync_enable_cfg_reg;

  // channel a word, reserved bits masked away
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan_a_reg <= COR_RST_CHAN_A;
    end else if (wr_ok & hit_a) begin
      chan_a_reg <= lane_merge(chan_a_reg, pwdata_i, pstrb_i, COR_MASK_OFS_ONLY);
    end
  end

  // preset and channel b word share one register, all bits live
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      preset_b_reg <= COR_RST_PRESET_B;
    end else if (wr_ok & hit_b) begin
      preset_b_reg <= lane_merge(preset_b_reg, pwdata_i, pstrb_i, COR_MASK_PRESET_OFS);
    end
  end

  // channel c word
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan_c_reg <= COR_RST_CHAN_C;
    end else if (wr_ok & hit_c) begin
      chan_c_reg <= lane_merge(chan_c_reg, pwdata_i, pstrb_i, COR_MASK_OFS_ONLY);
    end
  end

  // channel d word, staged only
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan_d_reg <= COR_RST_CHAN_D;
    end else if (wr_ok & hit_d) begin
      chan_d_reg <= lane_merge(chan_d_reg, pwdata_i, pstrb_i, COR_MASK_OFS_ONLY);
    end
  end

  // per-pair auto-sync enables
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      auto_sync_enable_cfg_reg <= COR_RST_AUTO_SYNC;
    end else if (wr_ok & hit_as & pstrb_i[0]) begin
      auto_sync_enable_cfg_reg <= pwdata_i[1:0];
    end
  end

  // ****************************************
  // pair sync generation
  // ****************************************
  logic sync_ab_reg;
  logic sync_cd_reg;
  logic force_ab;
  logic force_cd;

  // software kick in the sync control register, lane 0 only
  assign force_ab = wr_ok & hit_sync & pstrb_i[0] & pwdata_i[COR_AS_AB_BIT];
  assign force_cd = wr_ok & hit_sync & pstrb_i[0] & pwdata_i[COR_AS_CD_BIT];

  // the pulse lags the write by one edge, so the staged word it loads is
  // already the one just written; writes to b or d raise nothing
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_ab_reg <= 1'b0;
      sync_cd_reg <= 1'b0;
    end else begin
      sync_ab_reg <= (wr_ok & hit_a & auto_sync_enable_cfg_reg[COR_AS_AB_BIT]) |
                     force_ab | ext_sync_i;
      sync_cd_reg <= (wr_ok & hit_c & auto_sync_enable_cfg_reg[COR_AS_CD_BIT]) |
                     force_cd | ext_sync_i;
    end
  end

  // ****************************************
  // applied words
  // ****************************************
  logic [COR_OFS_W-1:0] appl_a;
  logic [COR_OFS_W-1:0] appl_b;
  logic [COR_OFS_W-1:0] appl_c;
  logic [COR_OFS_W-1:0] appl_d;

  // a/b pair moves together; b stays put on its own writes
  cor_pair_apply #(
    .W(COR_OFS_W)
  ) u_pair_ab (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .load_i(sync_ab_reg),
    .first_i(chan_a_reg[COR_OFS_LSB +: COR_OFS_W]),
    .second_i(preset_b_reg[COR_OFS_LSB +: COR_OFS_W]),
    .first_o(appl_a),
    .second_o(appl_b)
  );

  // c/d pair moves together; d stays put on its own writes
  cor_pair_apply #(
    .W(COR_OFS_W)
  ) u_pair_cd (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .load_i(sync_cd_reg),
    .first_i(chan_c_reg[COR_OFS_LSB +: COR_OFS_W]),
    .second_i(chan_d_reg[COR_OFS_LSB +: COR_OFS_W]),
    .first_o(appl_c),
    .second_o(appl_d)
  );

  assign chan_a_dc_correction_o = appl_a;
  assign chan_b_dc_correction_o = appl_b;
  assign chan_c_dc_correction_o = appl_c;
  assign chan_d_dc_correction_o = appl_d;

  // ****************************************
  // fifo read-pointer preset
  // ****************************************
  logic [COR_PRESET_W-1:0] fifo_rd_ptr_reg;
  logic fifo_rd_ptr_load_reg;

  // value and strobe leave together one edge after the sync event;
  // the preset is taken as it stands at the event, later writes wait
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fifo_rd_ptr_reg <= COR_RST_PRESET_B[COR_PRESET_LSB +: COR_PRESET_W];
      fifo_rd_ptr_load_reg <= 1'b0;
    end else begin
      fifo_rd_ptr_load_reg <= fifo_sync_i;
      if (fifo_sync_i) begin
        fifo_rd_ptr_reg <= preset_b_reg[COR_PRESET_LSB +: COR_PRESET_W];
      end
    end
  end

  assign fifo_rd_ptr_o = fifo_rd_ptr_reg;
  assign fifo_rd_ptr_load_o = fifo_rd_ptr_load_reg;

  // ****************************************
  // sync counters
  // ****************************************
  logic [CNT_W-1:0] cnt_ab_reg;
  logic [CNT_W-1:0] cnt_cd_reg;

  // wrap counters stepped once per pair sync, lets software see that a sync landed
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ab_reg <= '0;
      cnt_cd_reg <= '0;
    end else begin
      if (sync_ab_reg) begin
        cnt_ab_reg <= cnt_ab_reg + 1'b1;
      end
      if (sync_cd_reg) begin
        cnt_cd_reg <= cnt_cd_reg + 1'b1;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [COR_DATA_W-1:0] rd_mux;

  // unused bits and unmapped words read as zero
  always_comb begin
    rd_mux = '0;
    if (hit_a) begin
      rd_mux[COR_REG_W-1:0] = chan_a_reg;
    end
    if (hit_b) begin
      rd_mux[COR_REG_W-1:0] = preset_b_reg;
    end
    if (hit_c) begin
      rd_mux[COR_REG_W-1:0] = chan_c_reg;
    end
    if (hit_d) begin
      rd_mux[COR_REG_W-1:0] = chan_d_reg;
    end
    if (hit_as) begin
      rd_mux[1:0] = auto_sync_enable_cfg_reg;
    end
    if (hit_appl_ab) begin
      rd_mux[COR_APPL_LO_LSB +: COR_OFS_W] = appl_a;
      rd_mux[COR_APPL_HI_LSB +: COR_OFS_W] = appl_b;
    end
    if (hit_appl_cd) begin
      rd_mux[COR_APPL_LO_LSB +: COR_OFS_W] = appl_c;
      rd_mux[COR_APPL_HI_LSB +: COR_OFS_W] = appl_d;
    end
    if (hit_sync) begin
      rd_mux[COR_CNT_AB_LSB +: CNT_W] = cnt_ab_reg;
      rd_mux[COR_CNT_CD_LSB +: CNT_W] = cnt_cd_reg;
    end
  end

  // read data captured in the first access cycle, zero otherwise
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_reg <= '0;
    end else if (access_ph & ~pready_reg & ~pwrite_i) begin
      prdata_reg <= rd_mux;
    end else begin
      prdata_reg <= '0;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;

endmodule

//--- cor_regs_checker.sv
`timescale 1ns/1ps
// ****************************************
// register bank timing checks
// ****************************************
module cor_regs_checker #(
  parameter int CNT_W = cor_pkg::COR_CNT_W
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [cor_pkg::COR_ADDR_W-1:0] paddr_i,
  input wire logic [cor_pkg::COR_DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [cor_pkg::COR_DATA_W-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic fifo_sync_i,
  input wire logic [cor_pkg::COR_OFS_W-1:0] chan_a_dc_correction_o,
  input wire logic [cor_pkg::COR_OFS_W-1:0] chan_b_dc_correction_o,
  input wire logic [cor_pkg::COR_OFS_W-1:0] chan_c_dc_correction_o,
  input wire logic [cor_pkg::COR_OFS_W-1:0] chan_d_dc_correction_o,
  input wire logic [cor_pkg::COR_PRESET_W-1:0] fifo_rd_ptr_o,
  input wire logic fifo_rd_ptr_load_o
);
  import cor_pkg::*;
  logic [1:0] as_en_reg;
  logic wr_done;
  logic rd_done;
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_d;
  logic hit_as;
  // completion is the edge where the master samples pready
  assign wr_done = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_done = psel_i && penable_i && !pwrite_i && pready_o;
  assign hit_a = paddr_i == {2'h0, COR_IDX_CHAN_A, 2'h0};
  assign hit_b = paddr_i == {2'h0, COR_IDX_PRESET_B, 2'h0};
  assign hit_c = paddr_i == {2'h0, COR_IDX_CHAN_C, 2'h0};
  assign hit_d = paddr_i == {2'h0, COR_IDX_CHAN_D, 2'h0};
  assign hit_as = paddr_i == {2'h0, COR_IDX_AUTO_SYNC, 2'h0};
  // shadow of the enables, since the checker cannot see inside
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      as_en_reg <= COR_RST_AUTO_SYNC;
    end else if (wr_done && hit_as && pstrb_i[0]) begin
      as_en_reg <= pwdata_i[1:0];
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  property p_as_ab;
    wr_done && hit_a && as_en_reg[COR_AS_AB_BIT] |->
      ##2 chan_a_dc_correction_o == $past(pwdata_i[COR_OFS_W-1:0], 2);
  endproperty
  a_as_ab: assert property (p_as_ab) else $error("A word not applied by sync");
  property p_as_off;
    wr_done && hit_a && !as_en_reg[COR_AS_AB_BIT] |=> ##1 $stable(chan_a_dc_correction_o);
  endproperty
  a_as_off: assert property (p_as_off) else $error("A word moved with sync off");
  property p_as_cd;
    wr_done && hit_c && as_en_reg[COR_AS_CD_BIT] |->
      ##2 chan_c_dc_correction_o == $past(pwdata_i[COR_OFS_W-1:0], 2);
  endproperty
  a_as_cd: assert property (p_as_cd) else $error("C word not applied by sync");
  property p_b_stage;
    wr_done && hit_b |=> $stable(chan_b_dc_correction_o) [*2];
  endproperty
  a_b_stage: assert property (p_b_stage) else $error("B write moved applied B");
  property p_d_stage;
    wr_done && hit_d |=> $stable(chan_d_dc_correction_o) [*2];
  endproperty
  a_d_stage: assert property (p_d_stage) else $error("D write moved applied D");
  property p_fifo_load;
    fifo_sync_i |=> fifo_rd_ptr_load_o;
  endproperty
  a_fifo_load: assert property (p_fifo_load) else $error("no pointer load");
  property p_fifo_idle;
    !fifo_sync_i |=> !fifo_rd_ptr_load_o;
  endproperty
  a_fifo_idle: assert property (p_fifo_idle) else $error("stray pointer load");
  property p_rst_ptr;
    $rose(rst_b_i) |-> fifo_rd_ptr_o == 3'h4 && !fifo_rd_ptr_load_o;
  endproperty
  a_rst_ptr: assert property (p_rst_ptr) else $error("preset not 100 at reset");
  property p_rst_ofs;
    $rose(rst_b_i) |-> chan_a_dc_correction_o == '0 && chan_c_dc_correction_o == '0
      && chan_d_dc_correction_o == '0;
  endproperty
  a_rst_ofs: assert property (p_rst_ofs) else $error("offsets not zero at reset");
  property p_rsvd;
    rd_done && (hit_a || hit_c || hit_d) |-> prdata_o[COR_DATA_W-1:COR_OFS_W] == '0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
endmodule

bind cor_regs cor_regs_checker #(.CNT_W(CNT_W)) u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .fifo_sync_i(fifo_sync_i), .chan_a_dc_correction_o(chan_a_dc_correction_o),
  .chan_b_dc_correction_o(chan_b_dc_correction_o),
  .chan_c_dc_correction_o(chan_c_dc_correction_o),
  .chan_d_dc_correction_o(chan_d_dc_correction_o), .fifo_rd_ptr_o(fifo_rd_ptr_o),
  .fifo_rd_ptr_load_o(fifo_rd_ptr_load_o));

//--- tb.sv
`timescale 1ns/1ps
module tb;
  import cor_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [COR_ADDR_W-1:0] paddr_i = '0;
  logic [COR_DATA_W-1:0] pwdata_i = '0;
  logic [3:0] pstrb_i = 4'hF;
  logic fifo_sync_i = 1'b0;
  logic ext_sync_i = 1'b0;
  logic [COR_DATA_W-1:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [COR_OFS_W-1:0] ca;
  logic [COR_OFS_W-1:0] cb;
  logic [COR_OFS_W-1:0] cc;
  logic [COR_OFS_W-1:0] cd;
  logic [COR_PRESET_W-1:0] fifo_rd_ptr_o;
  logic fifo_rd_ptr_load_o;
  int errors = 0;
  int n_tests = 0;
  logic [32:0] exp_q[$];

  cor_regs u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .fifo_sync_i(fifo_sync_i), .ext_sync_i(ext_sync_i), .chan_a_dc_correction_o(ca),
    .chan_b_dc_correction_o(cb), .chan_c_dc_correction_o(cc), .chan_d_dc_correction_o(cd),
    .fifo_rd_ptr_o(fifo_rd_ptr_o), .fifo_rd_ptr_load_o(fifo_rd_ptr_load_o));

  always #50 mclk_i = ~mclk_i;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [COR_ADDR_W-1:0] ad(input logic [COR_IDX_W-1:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // one apb transfer; the expected answer is queued for the monitor
  task automatic apb(input logic wr, input logic [COR_ADDR_W-1:0] a,
                     input logic [31:0] d, input logic err, input logic [31:0] rd);
    int n;
    exp_q.push_back({err, wr ? 32'h0 : rd});
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      summarize();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // answers are taken in the cycle pready stands, oldest note first
  always @(posedge mclk_i) begin
    if (pready_o === 1'b1) begin
      if (exp_q.size() > 0) begin
        check({pslverr_o, prdata_o}, exp_q.pop_front());
      end else begin
        check(pready_o, 1'b0);
      end
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [COR_IDX_W-1:0] idx[4];
    logic [15:0] rstv[4];
    logic [15:0] msk[4];
    logic [15:0] v;
    logic [15:0] st;
    logic [15:0] tr;
    logic [15:0] ta;
    void'($urandom(32'h048615cf));
    idx = '{COR_IDX_CHAN_A, COR_IDX_PRESET_B, COR_IDX_CHAN_C, COR_IDX_CHAN_D};
    rstv = '{COR_RST_CHAN_A, COR_RST_PRESET_B, COR_RST_CHAN_C, COR_RST_CHAN_D};
    msk = '{COR_MASK_OFS_ONLY, COR_MASK_PRESET_OFS, COR_MASK_OFS_ONLY, COR_MASK_OFS_ONLY};
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    #1 check(fifo_rd_ptr_o, 3'h4);
    // reset values, then reserved bits set on write; sync still off
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ad(idx[i]), 32'h0, 1'b0, 32'(rstv[i]));
      v = 16'($urandom()) | 16'hE000;
      apb(1'b1, ad(idx[i]), {16'hFFFF, v}, 1'b0, 32'h0);
      apb(1'b0, ad(idx[i]), 32'h0, 1'b0, 32'(v & msk[i]));
    end
    check({ca, cb, cc, cd}, 52'h0);
    apb(1'b1, ad(COR_IDX_AUTO_SYNC), 32'h3, 1'b0, 32'h0);
    // stage the second word, then trigger with the first word of each pair
    for (int k = 0; k < 2; k++) begin
      st = 16'($urandom());
      tr = 16'($urandom()) & COR_MASK_OFS_ONLY;
      apb(1'b1, ad(k ? COR_IDX_CHAN_D : COR_IDX_PRESET_B), 32'(st), 1'b0, 32'h0);
      repeat (2) @(posedge mclk_i);
      #1 check(k ? cd : cb, 13'h0);
      if (k == 0) begin
        ta = tr;
      end
      apb(1'b1, ad(k ? COR_IDX_CHAN_C : COR_IDX_CHAN_A), 32'(tr), 1'b0, 32'h0);
      repeat (2) @(posedge mclk_i);
      #1 check(k ? {cc, cd} : {ca, cb}, {tr[12:0], st[12:0]});
    end
    // external sync loads staged words of both pairs
    st = 16'($urandom());
    tr = 16'($urandom());
    apb(1'b1, ad(COR_IDX_PRESET_B), 32'(st), 1'b0, 32'h0);
    apb(1'b1, ad(COR_IDX_CHAN_D), 32'(tr), 1'b0, 32'h0);
    @(posedge mclk_i) ext_sync_i <= 1'b1;
    @(posedge mclk_i) ext_sync_i <= 1'b0;
    @(posedge mclk_i);
    #1 check({cb, cd}, {st[12:0], tr[12:0] & 13'h1FFF});
    // fifo sync takes the preset of the last B register write
    @(posedge mclk_i) fifo_sync_i <= 1'b1;
    @(posedge mclk_i) fifo_sync_i <= 1'b0;
    #1 check({fifo_rd_ptr_load_o, fifo_rd_ptr_o}, {1'b1, st[15:13]});
    @(posedge mclk_i);
    #1 check(fifo_rd_ptr_load_o, 1'b0);
    // refused accesses leave applied words alone
    apb(1'b0, 12'h3FC, 32'h0, 1'b1, 32'h0);
    apb(1'b0, 12'h022, 32'h0, 1'b1, 32'h0);
    apb(1'b1, ad(COR_IDX_APPLIED_AB), 32'hFFFFFFFF, 1'b1, 32'h0);
    apb(1'b0, ad(COR_IDX_APPLIED_AB), 32'h0, 1'b0, {3'h0, st[12:0], 3'h0, ta[12:0]});
    // two syncs per pair so far; a forced sync adds one to each count
    apb(1'b0, ad(COR_IDX_SYNC_CTRL), 32'h0, 1'b0, 32'h00000202);
    apb(1'b1, ad(COR_IDX_SYNC_CTRL), 32'h3, 1'b0, 32'h0);
    apb(1'b0, ad(COR_IDX_SYNC_CTRL), 32'h0, 1'b0, 32'h00000303);
    repeat (3) @(posedge mclk_i);
    summarize();
  end
endmodule
